//--- hdl/dwc_pkg.sv
package dwc_pkg;
  // clock
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int IDX_W = 6;
  localparam int CH_N = 4;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_WD_CFG = 6'h0b;
  localparam logic [IDX_W-1:0] IDX_IN_CFG = 6'h0c;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h10;
  localparam logic [IDX_W-1:0] IDX_MASK = 6'h11;
  localparam logic [IDX_W-1:0] IDX_LEVEL = 6'h12;
  localparam logic [IDX_W-1:0] IDX_OVL = 6'h13;
  localparam logic [IDX_W-1:0] IDX_WD_STAT = 6'h14;

  // reset values
  localparam logic [REG_W-1:0] WD_CFG_RST = 8'h00;
  localparam logic [REG_W-1:0] IN_CFG_RST = 8'h08;
  localparam logic [3:0] MASK_RST = 4'h0;

  // watchdog_and_detect_config fields
  localparam int WATCHDOG_TIMEOUT_SEL_LSB = 6;
  localparam int PROBE_LSB = 4;
  localparam int SHORT_LSB = 2;
  localparam int SYNC_EN_BIT = 1;
  localparam int RAISED_UV_BIT = 0;

  // input_and_supply_fault_config fields
  localparam int TYPE_TWO_BIT = 7;
  localparam int RSVD_BIT = 6;
  localparam int MASK_ALL_BIT = 5;
  localparam int VIEW_BIT = 4;
  localparam int PROTECT_BIT = 3;
  localparam int HOLD_BIT = 2;
  localparam int BLANK_LSB = 0;

  // interrupt status / mask layout
  localparam int ST_SERIAL_WD = 0;
  localparam int ST_SYNC_WD = 1;
  localparam int ST_SUPPLY = 2;
  localparam int ST_OVERLOAD = 3;
  localparam int ST_W = 4;

  // watchdog status layout
  localparam int WS_SERIAL_EN = 0;
  localparam int WS_SYNC_EN = 1;
  localparam int WS_SERIAL_TO = 2;
  localparam int WS_SYNC_TO = 3;
  localparam int WS_SUPPLY = 4;

  // times in ms
  localparam int WD_T1_MS = 200;
  localparam int WD_T2_MS = 600;
  localparam int WD_T3_MS = 1200;
  localparam int SYNC_DEF_MS = 600;
  localparam int HOLD_MS = 100;
  localparam int BLANK1_MS = 8;
  localparam int BLANK2_MS = 50;
  localparam int BLANK3_MS = 300;

  localparam int CNT_W = 16;

  typedef enum logic {
    DWC_BUS_IDLE,
    DWC_BUS_ACK
  } dwc_bus_t;
endpackage : dwc_pkg

//--- hdl/dwc_ovl_if.sv
interface dwc_ovl_if;
  logic tick;
  logic [dwc_pkg::CNT_W-1:0] blank_ticks;
  logic [dwc_pkg::CNT_W-1:0] hold_ticks;
  logic hold_en;
  logic raw;
  logic fault;

  modport ctl (output tick, output blank_ticks, output hold_ticks, output hold_en, output raw, input fault);
  modport chan (input tick, input blank_ticks, input hold_ticks, input hold_en, input raw, output fault);
endinterface : dwc_ovl_if

//--- hdl/dwc_ovl_chan.sv
module dwc_ovl_chan (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // channel link
  dwc_ovl_if.chan ch
);
  typedef enum logic {
    DWC_OVL_CLEAR,
    DWC_OVL_FAULT
  } dwc_ovl_st_t;

  typedef struct packed {
    dwc_ovl_st_t st;
    logic [dwc_pkg::CNT_W-1:0] cnt;
  } dwc_ovl_state_t;

  dwc_ovl_state_t s_r;
  dwc_ovl_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    unique case (s_r.st)
      DWC_OVL_CLEAR: begin
        if (!ch.raw) begin
          s_nxt.cnt = '0;
        end else if (ch.blank_ticks == '0 || s_r.cnt >= ch.blank_ticks) begin
          s_nxt.st = DWC_OVL_FAULT;
          s_nxt.cnt = '0;
        end else if (ch.tick) begin
          s_nxt.cnt = s_r.cnt + 1'b1;
        end
      end
      DWC_OVL_FAULT: begin
        if (ch.raw) begin
          s_nxt.cnt = '0;
        end else if (!ch.hold_en || s_r.cnt >= ch.hold_ticks) begin
          s_nxt.st = DWC_OVL_CLEAR;
          s_nxt.cnt = '0;
        end else if (ch.tick) begin
          s_nxt.cnt = s_r.cnt + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_r <= '{st: DWC_OVL_CLEAR, cnt: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ch.fault = (s_r.st == DWC_OVL_FAULT);
endmodule : dwc_ovl_chan

//--- hdl/dwc_regs.sv
// Behaviour
// - watchdog_timeout_sel 00 turns the serial watchdog off; 01/10/11 enable it with 200ms/600ms/1.2s for both watchdogs.
// - with the serial watchdog off the sync watchdog obeys only its enable and times out at 600ms.
// - sync_pin_watchdog_enable switches the sync watchdog on or off; its timeout follows the serial selection when that is on.
// - offstate_probe_current_sel picks one of four off-state probe currents.
// - supply_short_threshold_sel picks one of four short-to-supply thresholds, 9V up to 14V.
// - raised_undervoltage_threshold selects the raised undervoltage thresholds, which also shape the per-channel ok faults.
// - input_type_two_select chooses type 2 inputs when set and types 1 and 3 when clear.
// - bit 6 of the input configuration is reserved, resets to 0 and software writes 0 there.
// - supply_fault_mask_all removes every supply-level fault from the supply error flag.
// - level_view_select makes the channel level register show supply-ok faults instead of pin levels.
// - with level_view_select clear the per-channel supply-ok faults never reach the supply error flag.
// - over_supply_protect_enable turns off a channel gate when that channel sees an above-supply fault.
// - overload_hold_enable keeps each overload fault set for at least 100ms.
// - overload_blank_sel gives no blanking or 8ms, 50ms, 300ms of blanking on every channel overload fault.
module dwc_regs #(
  parameter int TICK_HZ = 1000,
  parameter int TICK_DIV = dwc_pkg::CLK_HZ / TICK_HZ
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [dwc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [dwc_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [dwc_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // watchdog activity
  input wire logic serial_frame_ok,
  input wire logic sync_input_pin,
  // supply monitors
  input wire logic supply_uvlo,
  input wire logic supply_warn,
  input wire logic supply_low,
  input wire logic [dwc_pkg::CH_N-1:0] channel_supply_ok_fault,
  // channel pins
  input wire logic [dwc_pkg::CH_N-1:0] channel_pin,
  input wire logic [dwc_pkg::CH_N-1:0] above_supply_fault,
  input wire logic [dwc_pkg::CH_N-1:0] gate_request,
  input wire logic [dwc_pkg::CH_N-1:0] overload_raw,
  // configuration out
  output logic [1:0] offstate_probe_current_sel,
  output logic [1:0] supply_short_threshold_sel,
  output logic raised_undervoltage_threshold,
  output logic input_type_two_select,
  // status out
  output logic serial_watchdog_timeout,
  output logic sync_watchdog_timeout,
  output logic supply_error_flag,
  output logic [dwc_pkg::CH_N-1:0] gate_enable,
  output logic [dwc_pkg::CH_N-1:0] channel_overload_fault,
  output logic irq
);
  localparam int CW = dwc_pkg::CNT_W;

  generate
    if (TICK_HZ < 1 || TICK_HZ > 10000 || TICK_DIV < 1) begin : g_bad_tick
      $error("tick rate out of range");
    end
  endgenerate

  typedef struct packed {
    dwc_pkg::dwc_bus_t bus;
    logic wait_req;
    logic [dwc_pkg::DATA_W-1:0] rdata;
    logic [dwc_pkg::REG_W-1:0] wd_cfg;
    logic [dwc_pkg::REG_W-1:0] in_cfg;
    logic [dwc_pkg::ST_W-1:0] status;
    logic [dwc_pkg::ST_W-1:0] mask;
    logic irq;
    logic [31:0] tick_cnt;
    logic tick;
    logic [CW-1:0] swd_cnt;
    logic [CW-1:0] ywd_cnt;
    logic swd_to;
    logic ywd_to;
    logic sync_prev;
    logic supply_err;
    logic ovl_any;
    logic [dwc_pkg::CH_N-1:0] gate_en;
  } dwc_state_t;

  dwc_state_t s_r;
  dwc_state_t s_nxt;

  // ms to ticks, rounded up, never below one
  function automatic logic [CW-1:0] ms_to_ticks(input int ms);
    int t;
    t = (ms * TICK_HZ + dwc_pkg::MS_PER_S - 1) / dwc_pkg::MS_PER_S;
    if (t < 1) begin
      t = 1;
    end
    return CW'(t);
  endfunction : ms_to_ticks

  // watchdog timeout by selection
  function automatic logic [CW-1:0] wd_ticks(input logic [1:0] sel);
    logic [CW-1:0] r;
    unique case (sel)
      2'b01: r = ms_to_ticks(dwc_pkg::WD_T1_MS);
      2'b10: r = ms_to_ticks(dwc_pkg::WD_T2_MS);
      2'b11: r = ms_to_ticks(dwc_pkg::WD_T3_MS);
      2'b00: r = ms_to_ticks(dwc_pkg::SYNC_DEF_MS);
    endcase
    return r;
  endfunction : wd_ticks

  // blanking by selection, zero means none
  function automatic logic [CW-1:0] blank_ticks(input logic [1:0] sel);
    logic [CW-1:0] r;
    unique case (sel)
      2'b00: r = '0;
      2'b01: r = ms_to_ticks(dwc_pkg::BLANK1_MS);
      2'b10: r = ms_to_ticks(dwc_pkg::BLANK2_MS);
      2'b11: r = ms_to_ticks(dwc_pkg::BLANK3_MS);
    endcase
    return r;
  endfunction : blank_ticks

  // decoded configuration
  logic [1:0] watchdog_timeout_sel_sel;
  logic swd_en;
  logic ywd_en;
  logic [CW-1:0] swd_limit;
  logic [CW-1:0] ywd_limit;
  logic [dwc_pkg::CH_N-1:0] ovl_fault_w;
  logic [dwc_pkg::IDX_W-1:0] idx;
  logic addr_ok;

  assign watchdog_timeout_sel_sel = s_r.wd_cfg[dwc_pkg::WATCHDOG_TIMEOUT_SEL_LSB +: 2];
  assign swd_en = (watchdog_timeout_sel_sel != 2'b00);
  assign ywd_en = s_r.wd_cfg[dwc_pkg::SYNC_EN_BIT];
  assign swd_limit = wd_ticks(watchdog_timeout_sel_sel);
  assign ywd_limit = wd_ticks(watchdog_timeout_sel_sel);
  assign idx = avs_address[dwc_pkg::ADDR_W-1:2];
  assign addr_ok = (avs_address[1:0] == 2'b00);

  // per-channel overload timing
  generate
    for (genvar i = 0; i < dwc_pkg::CH_N; i++) begin : g_ch
      dwc_ovl_if ovl_if ();
      assign ovl_if.tick = s_r.tick;
      assign ovl_if.blank_ticks = blank_ticks(s_r.in_cfg[dwc_pkg::BLANK_LSB +: 2]);
      assign ovl_if.hold_ticks = ms_to_ticks(dwc_pkg::HOLD_MS);
      assign ovl_if.hold_en = s_r.in_cfg[dwc_pkg::HOLD_BIT];
      assign ovl_if.raw = overload_raw[i];
      assign ovl_fault_w[i] = ovl_if.fault;
      dwc_ovl_chan u_chan (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .ch(ovl_if.chan)
      );
    end
  endgenerate

  // read mux
  function automatic logic [dwc_pkg::DATA_W-1:0] read_mux(input logic [dwc_pkg::IDX_W-1:0] i, input dwc_state_t s);
    logic [dwc_pkg::DATA_W-1:0] d;
    d = '0;
    unique case (i)
      dwc_pkg::IDX_WD_CFG: d[dwc_pkg::REG_W-1:0] = s.wd_cfg;
      dwc_pkg::IDX_IN_CFG: d[dwc_pkg::REG_W-1:0] = s.in_cfg;
      dwc_pkg::IDX_STATUS: d[dwc_pkg::ST_W-1:0] = s.status;
      dwc_pkg::IDX_MASK: d[dwc_pkg::ST_W-1:0] = s.mask;
      dwc_pkg::IDX_LEVEL: begin
        if (s.in_cfg[dwc_pkg::VIEW_BIT]) begin
          d[dwc_pkg::CH_N-1:0] = channel_supply_ok_fault;
        end else begin
          d[dwc_pkg::CH_N-1:0] = channel_pin;
        end
      end
      dwc_pkg::IDX_OVL: d[dwc_pkg::CH_N-1:0] = ovl_fault_w;
      dwc_pkg::IDX_WD_STAT: begin
        d[dwc_pkg::WS_SERIAL_EN] = swd_en;
        d[dwc_pkg::WS_SYNC_EN] = ywd_en;
        d[dwc_pkg::WS_SERIAL_TO] = s.swd_to;
        d[dwc_pkg::WS_SYNC_TO] = s.ywd_to;
        d[dwc_pkg::WS_SUPPLY] = s.supply_err;
      end
      default: d = '0;
    endcase
    return d;
  endfunction : read_mux

  always_comb begin
    logic wr;
    logic [dwc_pkg::ST_W-1:0] clr;
    logic [dwc_pkg::ST_W-1:0] ev;
    logic sync_edge;
    logic ok_fault_in;
    wr = 1'b0;
    clr = '0;
    ev = '0;
    sync_edge = 1'b0;
    ok_fault_in = 1'b0;
    s_nxt = s_r;

    // bus: one wait cycle, write lands on the edge where waitrequest is low
    unique case (s_r.bus)
      dwc_pkg::DWC_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          s_nxt.bus = dwc_pkg::DWC_BUS_ACK;
          s_nxt.wait_req = 1'b0;
          s_nxt.rdata = (avs_read && addr_ok) ? read_mux(idx, s_r) : '0;
        end
      end
      dwc_pkg::DWC_BUS_ACK: begin
        s_nxt.bus = dwc_pkg::DWC_BUS_IDLE;
        s_nxt.wait_req = 1'b1;
        wr = avs_write && addr_ok && avs_byteenable[0];
      end
    endcase

    if (wr) begin
      unique case (idx)
        dwc_pkg::IDX_WD_CFG: s_nxt.wd_cfg = avs_writedata[dwc_pkg::REG_W-1:0];
        dwc_pkg::IDX_IN_CFG: s_nxt.in_cfg = avs_writedata[dwc_pkg::REG_W-1:0];
        dwc_pkg::IDX_STATUS: clr = avs_writedata[dwc_pkg::ST_W-1:0];
        dwc_pkg::IDX_MASK: s_nxt.mask = avs_writedata[dwc_pkg::ST_W-1:0];
        default: ;
      endcase
    end

    // tick generator
    if (s_r.tick_cnt >= 32'(TICK_DIV - 1)) begin
      s_nxt.tick_cnt = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 32'h0000_0001;
      s_nxt.tick = 1'b0;
    end

    // serial watchdog
    if (!swd_en || serial_frame_ok) begin
      s_nxt.swd_cnt = '0;
      s_nxt.swd_to = 1'b0;
    end else if (s_r.swd_cnt >= swd_limit) begin
      s_nxt.swd_to = 1'b1;
    end else if (s_r.tick) begin
      s_nxt.swd_cnt = s_r.swd_cnt + 1'b1;
    end

    // sync watchdog, restarted by any sync pin edge
    s_nxt.sync_prev = sync_input_pin;
    sync_edge = sync_input_pin ^ s_r.sync_prev;
    if (!ywd_en || sync_edge) begin
      s_nxt.ywd_cnt = '0;
      s_nxt.ywd_to = 1'b0;
    end else if (s_r.ywd_cnt >= ywd_limit) begin
      s_nxt.ywd_to = 1'b1;
    end else if (s_r.tick) begin
      s_nxt.ywd_cnt = s_r.ywd_cnt + 1'b1;
    end

    // supply error
    ok_fault_in = s_r.in_cfg[dwc_pkg::VIEW_BIT] && (|channel_supply_ok_fault);
    s_nxt.supply_err = !s_r.in_cfg[dwc_pkg::MASK_ALL_BIT] && (supply_uvlo || supply_warn || supply_low || ok_fault_in);

    // gate drive with over-supply cut-off
    s_nxt.gate_en = gate_request & ~({dwc_pkg::CH_N{s_r.in_cfg[dwc_pkg::PROTECT_BIT]}} & above_supply_fault);

    // interrupt events on rising faults, set wins over clear
    s_nxt.ovl_any = |ovl_fault_w;
    ev[dwc_pkg::ST_SERIAL_WD] = s_nxt.swd_to && !s_r.swd_to;
    ev[dwc_pkg::ST_SYNC_WD] = s_nxt.ywd_to && !s_r.ywd_to;
    ev[dwc_pkg::ST_SUPPLY] = s_nxt.supply_err && !s_r.supply_err;
    ev[dwc_pkg::ST_OVERLOAD] = s_nxt.ovl_any && !s_r.ovl_any;
    s_nxt.status = (s_r.status & ~clr) | ev;
    s_nxt.irq = |(s_nxt.status & ~s_nxt.mask);
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_r <= '{
        bus: dwc_pkg::DWC_BUS_IDLE,
        wait_req: 1'b1,
        rdata: '0,
        wd_cfg: dwc_pkg::WD_CFG_RST,
        in_cfg: dwc_pkg::IN_CFG_RST,
        status: '0,
        mask: dwc_pkg::MASK_RST,
        irq: 1'b0,
        tick_cnt: '0,
        tick: 1'b0,
        swd_cnt: '0,
        ywd_cnt: '0,
        swd_to: 1'b0,
        ywd_to: 1'b0,
        sync_prev: 1'b0,
        supply_err: 1'b0,
        ovl_any: 1'b0,
        gate_en: '0
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs
  assign avs_readdata = s_r.rdata;
  assign avs_waitrequest = s_r.wait_req;
  assign offstate_probe_current_sel = s_r.wd_cfg[dwc_pkg::PROBE_LSB +: 2];
  assign supply_short_threshold_sel = s_r.wd_cfg[dwc_pkg::SHORT_LSB +: 2];
  assign raised_undervoltage_threshold = s_r.wd_cfg[dwc_pkg::RAISED_UV_BIT];
  assign input_type_two_select = s_r.in_cfg[dwc_pkg::TYPE_TWO_BIT];
  assign serial_watchdog_timeout = s_r.swd_to;
  assign sync_watchdog_timeout = s_r.ywd_to;
  assign supply_error_flag = s_r.supply_err;
  assign gate_enable = s_r.gate_en;
  assign channel_overload_fault = ovl_fault_w;
  assign irq = s_r.irq;
endmodule : dwc_regs

//--- testbench/dwc_regs_monitor.sv
module dwc_regs_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // bus
  input wire logic [dwc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [dwc_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [dwc_pkg::DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // sources
  input wire logic supply_uvlo,
  input wire logic supply_warn,
  input wire logic supply_low,
  input wire logic [dwc_pkg::CH_N-1:0] channel_supply_ok_fault,
  input wire logic [dwc_pkg::CH_N-1:0] above_supply_fault,
  input wire logic [dwc_pkg::CH_N-1:0] gate_request,
  input wire logic [dwc_pkg::CH_N-1:0] overload_raw,
  // outputs
  input wire logic [1:0] offstate_probe_current_sel,
  input wire logic [1:0] supply_short_threshold_sel,
  input wire logic raised_undervoltage_threshold,
  input wire logic input_type_two_select,
  input wire logic supply_error_flag,
  input wire logic [dwc_pkg::CH_N-1:0] gate_enable,
  input wire logic [dwc_pkg::CH_N-1:0] channel_overload_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  ack_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  ack_cause_a: assert property ($fell(avs_waitrequest) |-> $past(avs_read || avs_write))
    else $error("acknowledge without request");
  unmapped_read_a: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
    |-> avs_readdata == 32'h0000_0000) else $error("misaligned read not zero");
  detect_cfg_a: assert property (
    avs_write && !avs_waitrequest && avs_address == 8'h2c |=>
    {offstate_probe_current_sel, supply_short_threshold_sel, raised_undervoltage_threshold}
    == {$past(avs_writedata[5:2]), $past(avs_writedata[0])}) else $error("detect config outputs wrong");
  input_type_a: assert property (
    avs_write && !avs_waitrequest && avs_address == 8'h30 |=> input_type_two_select == $past(avs_writedata[7]))
    else $error("input type output wrong");
  gate_off_a: assert property ($past(rstn) |-> (gate_enable & ~$past(gate_request)) == 4'h0
    && ((gate_enable ^ $past(gate_request)) & ~$past(above_supply_fault)) == 4'h0)
    else $error("gate enable does not follow request");
  supply_quiet_a: assert property ($past(rstn) &&
    !$past(supply_uvlo || supply_warn || supply_low || (|channel_supply_ok_fault)) |-> !supply_error_flag)
    else $error("supply error without source");
  overload_cause_a: assert property ($past(rstn) |-> (channel_overload_fault &
    ~$past(channel_overload_fault) & ~($past(overload_raw) | $past(overload_raw, 2))) == 4'h0)
    else $error("overload fault rose without raw fault");
endmodule : dwc_regs_monitor

bind dwc_regs dwc_regs_monitor i_dwc_regs_monitor (.ref_clk, .rstn, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .supply_uvlo, .supply_warn, .supply_low,
  .channel_supply_ok_fault, .above_supply_fault, .gate_request, .overload_raw, .offstate_probe_current_sel,
  .supply_short_threshold_sel, .raised_undervoltage_threshold, .input_type_two_select, .supply_error_flag,
  .gate_enable, .channel_overload_fault);

//--- testbench/tb_dwc_regs.sv
module tb_dwc_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rstn, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, v;
  logic [3:0] avs_byteenable, channel_supply_ok_fault, channel_pin, above_supply_fault, gate_request;
  logic [3:0] overload_raw, gate_enable, channel_overload_fault;
  logic serial_frame_ok, sync_input_pin, supply_uvlo, supply_warn, supply_low;
  logic [1:0] offstate_probe_current_sel, supply_short_threshold_sel;
  logic raised_undervoltage_threshold, input_type_two_select, serial_watchdog_timeout;
  logic sync_watchdog_timeout, supply_error_flag, irq;
  int n_fail, checks;

  dwc_regs #(.TICK_DIV(10)) i_dwc_regs (.ref_clk, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .serial_frame_ok, .sync_input_pin,
    .supply_uvlo, .supply_warn, .supply_low, .channel_supply_ok_fault, .channel_pin, .above_supply_fault,
    .gate_request, .overload_raw, .offstate_probe_current_sel, .supply_short_threshold_sel,
    .raised_undervoltage_threshold, .input_type_two_select, .serial_watchdog_timeout,
    .sync_watchdog_timeout, .supply_error_flag, .gate_enable, .channel_overload_fault, .irq);

  task report_and_stop;
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task chk_t(input string nm, input int lo, input int hi, input int g);
    checks++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_t

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      n_fail++;
      report_and_stop();
    end
  endtask : bus

  task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask : rdc

  function automatic logic probe(input int k);
    case (k)
      0: return serial_watchdog_timeout;
      1: return sync_watchdog_timeout;
      2: return channel_overload_fault[0];
      default: return !channel_overload_fault[0];
    endcase
  endfunction : probe

  function automatic int wdms(input int c);
    return c == 1 ? dwc_pkg::WD_T1_MS : c == 2 ? dwc_pkg::WD_T2_MS : dwc_pkg::WD_T3_MS;
  endfunction : wdms

  function automatic int blms(input int c);
    return c == 0 ? 0 : c == 1 ? dwc_pkg::BLANK1_MS : c == 2 ? dwc_pkg::BLANK2_MS : dwc_pkg::BLANK3_MS;
  endfunction : blms

  // cycles until the selected output goes high, or until the overload fault goes low for k 3, one tick is ten clocks
  task tm(input int k, input int ms, input string nm);
    int n;
    n = 0;
    while (probe(k) !== 1'b1 && n < ms * 10 + 13) begin
      @(posedge ref_clk);
      n++;
    end
    chk_t(nm, ms * 10 - 15, ms * 10 + 12, n);
    if (probe(k) !== 1'b1) begin
      report_and_stop();
    end
  endtask : tm

  task kick;
    @(posedge ref_clk);
    serial_frame_ok <= 1'b1;
    sync_input_pin <= !sync_input_pin;
    @(posedge ref_clk);
    serial_frame_ok <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : kick

  // event edge, then the edge that registers status and irq together, then one spare edge
  task irq_is(input logic e);
    repeat (3) @(posedge ref_clk);
    chk("irq", e, irq);
  endtask : irq_is

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    {rstn, avs_read, avs_write, avs_address, avs_writedata, serial_frame_ok, sync_input_pin} = '0;
    {supply_uvlo, supply_warn, supply_low, channel_supply_ok_fault, channel_pin} = '0;
    {above_supply_fault, gate_request, overload_raw} = '0;
    avs_byteenable = 4'hf;
    n_fail = 0;
    checks = 0;
    void'($urandom(32'ha8ca));
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    rdc(8'h2c, 32'h0000_0000, "wd cfg reset");
    rdc(8'h30, 32'h0000_0008, "in cfg reset");
    rdc(8'h44, 32'h0000_0000, "mask reset");
    rdc(8'h2d, 32'h0000_0000, "misaligned");
    rdc(8'h34, 32'h0000_0000, "unmapped");
    v = $urandom & 32'h0000_00bf;
    bus(1'b1, 8'h30, v);
    rdc(8'h30, v, "in cfg readback");
    $display("done: reset and access");
    for (int c = 1; c < 4; c++) begin
      bus(1'b1, 8'h2c, 32'(c << 6));
      kick();
      tm(0, wdms(c), "serial timeout");
      rdc(8'h2c, 32'(c << 6), "wd cfg readback");
    end
    bus(1'b1, 8'h2c, 32'h0000_0002);
    kick();
    tm(1, dwc_pkg::SYNC_DEF_MS, "sync default");
    chk("serial off", 1'b0, serial_watchdog_timeout);
    bus(1'b1, 8'h2c, 32'h0000_0042);
    kick();
    tm(1, dwc_pkg::WD_T1_MS, "sync follows");
    bus(1'b1, 8'h2c, 32'h0000_0040);
    bus(1'b0, 8'h50, 32'h0000_0000);
    chk("wd enables", 32'h0000_0001, rd & 32'h0000_0003);
    irq_is(1'b1);
    chk("sync off", 1'b0, sync_watchdog_timeout);
    $display("done: watchdogs");
    for (int c = 0; c < 4; c++) begin
      v = {26'h0, 2'(c), ~2'(c), 1'b0, 1'($urandom)};
      bus(1'b1, 8'h2c, v);
      irq_is(1'b1);
      chk("detect cfg", {v[5:2], v[0]}, {offstate_probe_current_sel, supply_short_threshold_sel,
        raised_undervoltage_threshold});
    end
    bus(1'b1, 8'h30, 32'h0000_0088);
    irq_is(1'b1);
    chk("type two", 1'b1, input_type_two_select);
    $display("done: config outputs");
    for (int i = 0; i < 10; i++) begin
      v = i == 0 ? 32'h000f_f0f0 : i == 1 ? 32'h000f_f0f3 : $urandom;
      bus(1'b1, 8'h30, {26'h0, v[2:0], 3'h0});
      supply_uvlo <= v[3];
      supply_warn <= v[20] & v[22];
      supply_low <= v[21] & v[22];
      channel_supply_ok_fault <= v[7:4];
      channel_pin <= v[11:8];
      above_supply_fault <= v[15:12];
      gate_request <= v[19:16];
      repeat (3) @(posedge ref_clk);
      chk("supply error", !v[2] & (v[3] | (v[22] & |v[21:20]) | (v[1] & |v[7:4])), supply_error_flag);
      chk("gate", v[19:16] & ~({4{v[0]}} & v[15:12]), gate_enable);
      rdc(8'h48, v[1] ? v[7:4] : v[11:8], "level view");
    end
    {supply_uvlo, supply_warn, supply_low, channel_supply_ok_fault} <= '0;
    $display("done: supply, gate, level");
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, 8'h30, 32'(8 + c * 5 % 8));
      overload_raw <= 4'h1;
      tm(2, blms(c * 5 % 4), "blanking");
      repeat (5) @(posedge ref_clk);
      overload_raw <= 4'h0;
      tm(3, c[0] ? dwc_pkg::HOLD_MS : 0, "hold");
    end
    $display("done: overload timing");
    bus(1'b1, 8'h44, 32'h0000_000f);
    irq_is(1'b0);
    bus(1'b1, 8'h40, 32'h0000_000f);
    rdc(8'h40, 32'h0000_0000, "status cleared");
    bus(1'b1, 8'h44, 32'h0000_0000);
    irq_is(1'b0);
    bus(1'b1, 8'h30, 32'h0000_0008);
    overload_raw <= 4'h2;
    irq_is(1'b1);
    rdc(8'h40, 32'h0000_0008, "status overload");
    bus(1'b1, 8'h44, 32'h0000_0008);
    irq_is(1'b0);
    bus(1'b1, 8'h44, 32'h0000_0000);
    irq_is(1'b1);
    bus(1'b1, 8'h40, 32'h0000_0008);
    irq_is(1'b0);
    $display("done: interrupt");
    report_and_stop();
  end
endmodule : tb_dwc_regs
